// ### verilog/sccfg_pkg.sv
package sccfg_pkg;
  // register addresses
  localparam logic [7:0] ADDR_REINIT = 8'h01;
  localparam logic [7:0] ADDR_TONE_SWEEP = 8'h04;
  localparam logic [7:0] ADDR_START_FREQ = 8'h06;
  localparam logic [7:0] ADDR_STOP_FREQ = 8'h07;
  localparam logic [7:0] ADDR_STEP_FREQ = 8'h08;
  localparam logic [7:0] ADDR_DWELL = 8'h09;
  localparam logic [7:0] ADDR_CYCLES = 8'h0a;
  localparam logic [7:0] ADDR_SPARE_0B = 8'h0b;
  localparam logic [7:0] ADDR_LIST_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_LIST_ENTRY = 8'h0d;
  localparam logic [7:0] ADDR_LIST_XFER = 8'h0e;
  localparam logic [7:0] ADDR_SOFT_TRIG = 8'h0f;
  localparam logic [7:0] ADDR_OUT_FREQ = 8'h10;
  localparam logic [7:0] ADDR_POWER = 8'h11;
  localparam logic [7:0] ADDR_OUT_EN = 8'h12;
  localparam logic [7:0] ADDR_PHASE = 8'h13;
  localparam logic [7:0] ADDR_AUTO_LVL_OFF = 8'h14;
  localparam logic [7:0] ADDR_LOOP_MODE = 8'h15;
  localparam logic [7:0] ADDR_STANDBY = 8'h16;
  localparam logic [7:0] ADDR_REF_CFG = 8'h17;
  localparam logic [7:0] ADDR_REF_DAC = 8'h18;
  localparam logic [7:0] ADDR_LVL_DAC = 8'h19;
  localparam logic [7:0] ADDR_SPARE_1A = 8'h1a;
  localparam logic [7:0] ADDR_SAVE_STATE = 8'h1b;
  localparam logic [7:0] ADDR_SPARE_1C = 8'h1c;
  localparam logic [7:0] ADDR_SPARE_1D = 8'h1d;
  localparam logic [7:0] ADDR_STANDBY2 = 8'h1e;
  localparam logic [7:0] ADDR_FREQ2 = 8'h1f;
  // payload lengths in bytes
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_HALF = 3'h2;
  localparam logic [2:0] LEN_WORD = 3'h4;
  localparam logic [2:0] LEN_FREQ = 3'h5;
  // list memory geometry and dac width
  localparam int LIST_AW = 8;
  localparam int FREQ_W = 40;
  localparam int DAC_W = 14;
  // power-up values
  localparam logic [39:0] RST_OUT_FREQ = 40'h0000000000;
  localparam logic [15:0] RST_POWER = 16'h0000;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [15:0] RST_FREQ2 = 16'h0000;
  localparam logic [15:0] RST_LIST_COUNT = 16'h0000;
  localparam logic [13:0] RST_DAC = 14'h0000;
  localparam logic RST_OUT_EN = 1'b1;
  localparam logic RST_STANDBY = 1'b0;
  localparam logic RST_STANDBY2 = 1'b1;
  localparam logic RST_LOOP_MODE = 1'b0;
  localparam logic RST_AUTO_LVL_OFF = 1'b0;
  localparam logic RST_SWEEP_SEL = 1'b0;
  localparam logic [1:0] RST_REF_CFG = 2'h0;
  // bit positions
  localparam int BIT_MODE = 0;
  localparam int BIT_REF_OUT = 1;
endpackage

// ### verilog/sccfg_list_mem.sv
`timescale 1ns/1ps
module sccfg_list_mem
  import sccfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [LIST_AW-1:0] wr_addr_i,
  input wire logic [FREQ_W-1:0] wr_data_i,
  input wire logic [LIST_AW-1:0] rd_addr_i,
  output logic [FREQ_W-1:0] rd_data_o
);
  logic [FREQ_W-1:0] mem_ff [0:(1<<LIST_AW)-1];

  // write port
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i)
  begin
    rd_data_o <= mem_ff[rd_addr_i];
  end
endmodule

// ### verilog/sccfg_regs.sv
`timescale 1ns/1ps
module sccfg_regs
  import sccfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_data_i,
  input wire logic frame_start_i,
  input wire logic [LIST_AW-1:0] list_rd_addr_i,
  output logic [FREQ_W-1:0] list_rd_data_o,
  output logic [39:0] out_freq_o,
  output logic [15:0] power_level_o,
  output logic out_enable_o,
  output logic [15:0] phase_o,
  output logic auto_level_off_o,
  output logic loop_mode_o,
  output logic standby_o,
  output logic [1:0] ref_cfg_o,
  output logic [13:0] ref_dac_o,
  output logic [13:0] level_dac_o,
  output logic standby2_o,
  output logic [15:0] freq2_o,
  output logic tone_or_sweep_select_o,
  output logic [15:0] list_count_o,
  output logic list_xfer_pulse_o,
  output logic list_xfer_mode_o,
  output logic soft_trigger_o,
  output logic save_state_o,
  output logic reinit_pulse_o,
  output logic reinit_keep_o,
  output logic [LIST_AW-1:0] list_wr_ptr_o,
  output logic busy_o
);
  typedef enum logic [1:0] {SCCFG_IDLE, SCCFG_DATA} sccfg_state_type;

  sccfg_state_type state_ff;
  logic [7:0] addr_ff;
  logic [2:0] need_ff;
  logic [2:0] cnt_ff;
  logic [39:0] shreg_ff;
  logic commit;
  logic [39:0] word;
  logic [2:0] nxt_need;
  logic soft_reset;
  logic nxt_busy;
  logic list_wr_en;
  logic [LIST_AW-1:0] list_ptr_ff;

  ////////////////////////////////////////////////////////////////
  // byte length per address, decoded from the incoming address byte
  always_comb
  begin
    case (byte_data_i)
      ADDR_LIST_COUNT, ADDR_POWER, ADDR_PHASE, ADDR_REF_DAC, ADDR_LVL_DAC,
      ADDR_FREQ2: nxt_need = LEN_HALF;
      ADDR_DWELL, ADDR_CYCLES: nxt_need = LEN_WORD;
      ADDR_START_FREQ, ADDR_STOP_FREQ, ADDR_STEP_FREQ, ADDR_LIST_ENTRY,
      ADDR_OUT_FREQ: nxt_need = LEN_FREQ;
      default: nxt_need = LEN_BYTE;
    endcase
  end

  // frame parser: address byte then payload; exact length assumed
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= SCCFG_IDLE;
      addr_ff <= 8'h00;
      need_ff <= 3'h0;
      cnt_ff <= 3'h0;
    end
    else if (frame_start_i)
    begin
      state_ff <= SCCFG_IDLE;
      cnt_ff <= 3'h0;
    end
    else if (byte_valid_i)
    begin
      case (state_ff)
        SCCFG_IDLE:
        begin
          addr_ff <= byte_data_i;
          need_ff <= nxt_need;
          cnt_ff <= 3'h0;
          state_ff <= SCCFG_DATA;
        end
        SCCFG_DATA:
        begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff + 3'h1 == need_ff)
          begin
            state_ff <= SCCFG_IDLE;
          end
        end
        default: state_ff <= SCCFG_IDLE;
      endcase
    end
  end

  // payload assembly, first serial byte is least significant
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      shreg_ff <= 40'h0000000000;
    end
    else if (byte_valid_i && state_ff == SCCFG_DATA)
    begin
      shreg_ff[cnt_ff*8 +: 8] <= byte_data_i;
    end
  end

  assign commit = byte_valid_i && !frame_start_i && state_ff == SCCFG_DATA
    && (cnt_ff + 3'h1 == need_ff);

  // complete word including the byte arriving now
  always_comb
  begin
    word = shreg_ff;
    word[cnt_ff*8 +: 8] = byte_data_i;
  end

  assign soft_reset = commit && addr_ff == ADDR_REINIT && word[BIT_MODE];

  // busy follows the next parser state, so it rises with the address byte
  assign nxt_busy = frame_start_i ? 1'b0 :
    (byte_valid_i ? !commit : state_ff == SCCFG_DATA);

  ////////////////////////////////////////////////////////////////
  // write-only settings; no read path exists, spare addresses store nothing
  // tone or sweep select, bit 0 of its byte
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      tone_or_sweep_select_o <= RST_SWEEP_SEL;
    end
    else if (commit && addr_ff == ADDR_TONE_SWEEP)
    begin
      tone_or_sweep_select_o <= word[BIT_MODE];
    end
  end

  // list point count, low byte first
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      list_count_o <= RST_LIST_COUNT;
    end
    else if (commit && addr_ff == ADDR_LIST_COUNT)
    begin
      list_count_o <= word[15:0];
    end
  end

  // output frequency in hertz; frozen while tone_or_sweep_select_o is set
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      out_freq_o <= RST_OUT_FREQ;
    end
    else if (commit && addr_ff == ADDR_OUT_FREQ && !tone_or_sweep_select_o)
    begin
      out_freq_o <= word;
    end
  end

  // output power word, sign in the top bit
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      power_level_o <= RST_POWER;
    end
    else if (commit && addr_ff == ADDR_POWER)
    begin
      power_level_o <= word[15:0];
    end
  end

  // phase word in tenths of a degree, sign in the top bit
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      phase_o <= RST_PHASE;
    end
    else if (commit && addr_ff == ADDR_PHASE)
    begin
      phase_o <= word[15:0];
    end
  end

  // single-bit mode flags, bit 0 of their byte
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      out_enable_o <= RST_OUT_EN;
      auto_level_off_o <= RST_AUTO_LVL_OFF;
      loop_mode_o <= RST_LOOP_MODE;
      standby_o <= RST_STANDBY;
      standby2_o <= RST_STANDBY2;
    end
    else if (commit)
    begin
      case (addr_ff)
        ADDR_OUT_EN: out_enable_o <= word[BIT_MODE];
        ADDR_AUTO_LVL_OFF: auto_level_off_o <= word[BIT_MODE];
        ADDR_LOOP_MODE: loop_mode_o <= word[BIT_MODE];
        ADDR_STANDBY: standby_o <= word[BIT_MODE];
        ADDR_STANDBY2: standby2_o <= word[BIT_MODE];
        default: ; // other addresses leave the flags alone
      endcase
    end
  end

  // reference setup: output select and lock enable
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      ref_cfg_o <= RST_REF_CFG;
    end
    else if (commit && addr_ff == ADDR_REF_CFG)
    begin
      ref_cfg_o <= word[BIT_REF_OUT:BIT_MODE];
    end
  end

  // reference tuning dac, open top bits dropped
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      ref_dac_o <= RST_DAC;
    end
    else if (commit && addr_ff == ADDR_REF_DAC)
    begin
      ref_dac_o <= word[DAC_W-1:0];
    end
  end

  // level loop dac, open top bits dropped
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      level_dac_o <= RST_DAC;
    end
    else if (commit && addr_ff == ADDR_LVL_DAC)
    begin
      level_dac_o <= word[DAC_W-1:0];
    end
  end

  // second output frequency in megahertz
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      freq2_o <= RST_FREQ2;
    end
    else if (commit && addr_ff == ADDR_FREQ2)
    begin
      freq2_o <= word[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // one-cycle command strobes, plus the held list transfer mode bit
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      list_xfer_pulse_o <= 1'b0;
      list_xfer_mode_o <= 1'b0;
      soft_trigger_o <= 1'b0;
      save_state_o <= 1'b0;
      reinit_pulse_o <= 1'b0;
      reinit_keep_o <= 1'b0;
    end
    else
    begin
      list_xfer_pulse_o <= commit && addr_ff == ADDR_LIST_XFER;
      if (commit && addr_ff == ADDR_LIST_XFER)
      begin
        list_xfer_mode_o <= word[BIT_MODE];
      end
      soft_trigger_o <= commit && addr_ff == ADDR_SOFT_TRIG;
      save_state_o <= commit && addr_ff == ADDR_SAVE_STATE;
      reinit_pulse_o <= commit && addr_ff == ADDR_REINIT;
      reinit_keep_o <= commit && addr_ff == ADDR_REINIT && !word[BIT_MODE];
    end
  end

  ////////////////////////////////////////////////////////////////
  // list buffer write pointer, advances per entry
  assign list_wr_en = commit && addr_ff == ADDR_LIST_ENTRY;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      list_ptr_ff <= '0;
    end
    else if (commit && addr_ff == ADDR_LIST_COUNT)
    begin
      list_ptr_ff <= '0; // new list restarts loading
    end
    else if (list_wr_en)
    begin
      list_ptr_ff <= list_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      list_wr_ptr_o <= '0;
      busy_o <= 1'b0;
    end
    else
    begin
      list_wr_ptr_o <= list_ptr_ff;
      busy_o <= nxt_busy;
    end
  end

  sccfg_list_mem u_list_mem (
    .clk_i(clk_i),
    .wr_en_i(list_wr_en),
    .wr_addr_i(list_ptr_ff),
    .wr_data_i(word),
    .rd_addr_i(list_rd_addr_i),
    .rd_data_o(list_rd_data_o)
  );
endmodule

// ### tb/sccfg_asserts.sv
`timescale 1ns/1ps
module sccfg_asserts
  import sccfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_data_i,
  input wire logic frame_start_i,
  input wire logic [39:0] out_freq_o,
  input wire logic out_enable_o,
  input wire logic standby2_o,
  input wire logic tone_or_sweep_select_o,
  input wire logic reinit_pulse_o,
  input wire logic reinit_keep_o,
  input wire logic [LIST_AW-1:0] list_wr_ptr_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // settings and parser behaviour
  AST_RESET_VALUES: assert property ($rose(rst_n_i) |->
    out_freq_o == RST_OUT_FREQ && out_enable_o && standby2_o) else $error("bad reset values");
  AST_SWEEP_HOLDS: assert property (tone_or_sweep_select_o && $past(tone_or_sweep_select_o)
    |-> $stable(out_freq_o)) else $error("frequency moved in sweep mode");
  AST_PULSE_SHORT: assert property (reinit_pulse_o |=> !reinit_pulse_o)
    else $error("reinit pulse too long");
  AST_KEEP_PAIRED: assert property (reinit_keep_o |-> reinit_pulse_o)
    else $error("keep pulse without reinit");
  AST_FREQ_PAYLOAD: assert property (!busy_o && byte_valid_i && !frame_start_i
    && byte_data_i == ADDR_OUT_FREQ |=> busy_o [*4]) else $error("payload not awaited");
  AST_ABORT_IDLE: assert property (frame_start_i |=> !busy_o)
    else $error("abort left parser busy");
  AST_FREQ_ON_BYTE: assert property ($changed(out_freq_o) |-> $past(byte_valid_i))
    else $error("frequency changed without a byte");
  AST_PTR_STEP: assert property ($changed(list_wr_ptr_o) |->
    list_wr_ptr_o == $past(list_wr_ptr_o) + 8'h01 || list_wr_ptr_o == 8'h00)
    else $error("list pointer jumped");
endmodule

// ### tb/sccfg_host_model.sv
`timescale 1ns/1ps
module sccfg_host_model
(
  input wire logic clk_i,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic frame_start_o
);
  // idle line at time zero
  initial
  begin
    byte_valid_o = 1'b0;
    byte_data_o = 8'h5a;
    frame_start_o = 1'b0;
  end
  // address byte, then n payload bytes low first, then the line is released
  task wr(input logic [7:0] a, input logic [2:0] n, input logic [39:0] v);
    int k;
    @(posedge clk_i);
    #1 byte_valid_o = 1'b1;
    byte_data_o = a;
    for (k = 0; k < n; k++)
    begin
      @(posedge clk_i);
      #1 byte_data_o = v[8*k+:8];
    end
    @(posedge clk_i);
    #1 byte_valid_o = 1'b0;
    byte_data_o = ~byte_data_o;
  endtask
  // resync pulse after a short write
  task abort;
    @(posedge clk_i);
    #1 frame_start_o = 1'b1;
    @(posedge clk_i);
    #1 frame_start_o = 1'b0;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import sccfg_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic bv, fs, en, sel, sb2;
  logic [7:0] bd, ptr;
  logic [7:0] rd_a = 8'h00;
  logic [39:0] freq, rd_d;
  logic [15:0] cnt;
  logic [13:0] ldac, rdac;
  logic [15:0] pwr, ph, f2;
  logic [1:0] refc;
  logic alo, lm, sb, xp, xm, st, ss, rp, rk;
  int err_total = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #2.5 clk_i = ~clk_i;
  sccfg_host_model host (.clk_i(clk_i), .byte_valid_o(bv), .byte_data_o(bd), .frame_start_o(fs));
  sccfg_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .byte_valid_i(bv), .byte_data_i(bd),
    .frame_start_i(fs), .list_rd_addr_i(rd_a), .list_rd_data_o(rd_d), .out_freq_o(freq),
    .power_level_o(pwr), .out_enable_o(en), .phase_o(ph), .auto_level_off_o(alo),
    .loop_mode_o(lm), .standby_o(sb), .ref_cfg_o(refc), .ref_dac_o(rdac), .level_dac_o(ldac),
    .standby2_o(sb2), .freq2_o(f2), .tone_or_sweep_select_o(sel), .list_count_o(cnt),
    .list_xfer_pulse_o(xp), .list_xfer_mode_o(xm), .soft_trigger_o(st), .save_state_o(ss),
    .reinit_pulse_o(rp), .reinit_keep_o(rk), .list_wr_ptr_o(ptr), .busy_o());
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [39:0] e, input logic [39:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task do_reset;
    @(posedge clk_i);
    #1 rst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
  endtask
  // short write aborted, then a full one
  task t_freq;
    host.wr(ADDR_OUT_FREQ, 3'h2, 40'hffff);
    host.abort;
    host.wr(ADDR_OUT_FREQ, LEN_FREQ, 40'h123456789a);
    chk("out_freq", 40'h123456789a, freq);
  endtask
  task t_list;
    host.wr(ADDR_LIST_COUNT, LEN_HALF, 40'hbeef);
    chk("list_count", 40'hbeef, {24'h0, cnt});
    host.wr(ADDR_LIST_ENTRY, LEN_FREQ, 40'h0102030405);
    host.wr(ADDR_LIST_ENTRY, LEN_FREQ, 40'h0a0b0c0d0e);
    rd_a = 8'h01;
    @(posedge clk_i);
    #1 chk("list_ptr", 40'h2, {32'h0, ptr});
    chk("list_entry", 40'h0a0b0c0d0e, rd_d);
  endtask
  // open top bits of the dac word are dropped
  task t_dac;
    host.wr(ADDR_LVL_DAC, LEN_HALF, 40'hffff);
    chk("level_dac", 40'h3fff, {26'h0, ldac});
    host.wr(ADDR_LVL_DAC, LEN_HALF, 40'hc001);
    chk("level_dac", 40'h0001, {26'h0, ldac});
  endtask
  // a four-byte register must be skipped whole, then power, phase, freq2, reference, mode flags and strobes
  task t_misc;
    host.wr(ADDR_DWELL, LEN_WORD, 40'h10101010);
    host.wr(ADDR_POWER, LEN_HALF, 40'h8123);
    chk("power", 40'h8123, {24'h0, pwr});
    host.wr(ADDR_PHASE, LEN_HALF, 40'h0e10);
    chk("phase", 40'h0e10, {24'h0, ph});
    host.wr(ADDR_FREQ2, LEN_HALF, 40'h05dc);
    chk("freq2", 40'h05dc, {24'h0, f2});
    host.wr(ADDR_REF_DAC, LEN_HALF, 40'h1234);
    chk("ref_dac", 40'h1234, {26'h0, rdac});
    host.wr(ADDR_REF_CFG, LEN_BYTE, 40'h03);
    chk("ref_cfg", 40'h3, {38'h0, refc});
    host.wr(ADDR_AUTO_LVL_OFF, LEN_BYTE, 40'h01);
    host.wr(ADDR_LOOP_MODE, LEN_BYTE, 40'h01);
    host.wr(ADDR_STANDBY, LEN_BYTE, 40'h01);
    host.wr(ADDR_STANDBY2, LEN_BYTE, 40'h00);
    chk("mode_flags", 40'he, {36'h0, alo, lm, sb, sb2});
    host.wr(ADDR_LIST_XFER, LEN_BYTE, 40'h01);
    chk("list_xfer", 40'h3, {38'h0, xp, xm});
    host.wr(ADDR_SOFT_TRIG, LEN_BYTE, 40'h00);
    chk("soft_trigger", 40'h1, {39'h0, st});
    host.wr(ADDR_SAVE_STATE, LEN_BYTE, 40'h00);
    chk("save_state", 40'h1, {39'h0, ss});
  endtask
  task t_sweep;
    host.wr(ADDR_TONE_SWEEP, LEN_BYTE, 40'h01);
    host.wr(ADDR_OUT_FREQ, LEN_FREQ, 40'h5555555555);
    chk("out_freq", 40'h123456789a, freq);
    host.wr(ADDR_SPARE_1A, LEN_BYTE, 40'hff);
    host.wr(ADDR_TONE_SWEEP, LEN_BYTE, 40'h00);
    chk("sweep_select", 40'h0, {39'h0, sel});
    chk("out_freq", 40'h123456789a, freq);
  endtask
  task t_reinit;
    host.wr(ADDR_OUT_EN, LEN_BYTE, 40'h00);
    host.wr(ADDR_REINIT, LEN_BYTE, 40'hfe);
    chk("reinit_strobes", 40'h3, {38'h0, rp, rk});
    chk("out_freq", 40'h123456789a, freq);
    chk("out_enable", 40'h0, {39'h0, en});
    host.wr(ADDR_REINIT, LEN_BYTE, 40'h01);
    chk("reinit_strobes", 40'h2, {38'h0, rp, rk});
    chk("out_freq", RST_OUT_FREQ, freq);
    chk("power", {24'h0, RST_POWER}, {24'h0, pwr});
    chk("out_enable", {39'h0, RST_OUT_EN}, {39'h0, en});
    chk("standby2", {39'h0, RST_STANDBY2}, {39'h0, sb2});
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset;
    t_freq;
    t_list;
    t_dac;
    t_misc;
    t_sweep;
    t_reinit;
    host.wr(ADDR_OUT_FREQ, LEN_FREQ, 40'h0000000777);
    chk("out_freq", 40'h0000000777, freq);
    do_reset;
    chk("out_freq", RST_OUT_FREQ, freq);
    tally_and_finish;
  end
  // watchdog
  initial
  begin
    #20000;
    err_total++;
    tally_and_finish;
  end
endmodule
bind sccfg_regs sccfg_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .byte_valid_i(byte_valid_i), .byte_data_i(byte_data_i), .frame_start_i(frame_start_i),
  .out_freq_o(out_freq_o), .out_enable_o(out_enable_o), .standby2_o(standby2_o),
  .tone_or_sweep_select_o(tone_or_sweep_select_o), .reinit_pulse_o(reinit_pulse_o),
  .reinit_keep_o(reinit_keep_o), .list_wr_ptr_o(list_wr_ptr_o), .busy_o(busy_o));
